// File: hw/sfp_pkg.sv
// Shared constants and types of the serial flash pin interface.
package sfp_pkg;
  // Core clock and self-timed program/erase duration
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_US = 1000;
  localparam int PROG_CYC =
    (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Page and buffer geometry
  localparam int PAGE_BIG = 528;
  localparam int PAGE_SMALL = 512;
  localparam int BUF_AW = 10;
  localparam int SECTORS = 8;

  // Frame layout: opcode bits, address bits, byte bits
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Address bit that picks one of the two buffers
  localparam int BUF_SEL_BIT = 23;

  // Synchroniser reset value {reset_n, wp_n, si, sck, cs_n}
  localparam logic [4:0] SYNC_RST = 5'h1D;

  // Command codes (arbitrary values)
  localparam logic [7:0] OP_BUF_WR = 8'h84;
  localparam logic [7:0] OP_BUF_RD = 8'hD4;
  localparam logic [7:0] OP_PROG = 8'h83;
  localparam logic [7:0] OP_ERASE = 8'h81;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  localparam logic [7:0] OP_PROT_WR = 8'hFC;
  localparam logic [7:0] OP_PROT_EN = 8'h3D;
  localparam logic [7:0] OP_LOCK = 8'h3A;
  localparam logic [7:0] OP_PAGE512 = 8'hA6;

  // Frame states, one-hot
  typedef enum logic [5:0] {
    SFP_IDLE = 6'h01,
    SFP_OPC = 6'h02,
    SFP_ADDR = 6'h04,
    SFP_WR = 6'h08,
    SFP_RD = 6'h10,
    SFP_SKIP = 6'h20
  } sfp_state_e;
endpackage

// File: hw/sfp_buf_if.sv
// Port bundle between the frame logic and the page buffers.
interface sfp_buf_if;
  logic we;
  logic sel;
  logic [sfp_pkg::BUF_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctl (output we, sel, addr, wdata, input rdata);
  modport mem (input we, sel, addr, wdata, output rdata);
endinterface

// File: hw/sfp_page_buf.sv
// Two independent page-sized SRAM data buffers.
module sfp_page_buf #(
  parameter int BYTES = sfp_pkg::PAGE_BIG
) (
  // Clock
  input wire logic core_clk,
  // Buffer access
  sfp_buf_if.mem bus
);
  logic [7:0] mem [2][BYTES];

  // Write one byte, registered read of the addressed byte
  always_ff @(posedge core_clk) begin
    if (bus.we) begin
      mem[bus.sel][bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.sel][bus.addr];
  end
endmodule

// File: hw/sfp_flash_pins.sv
// Pin-level serial interface and control of the serial flash.
module sfp_flash_pins #(
  parameter int PROG_CYCLES = sfp_pkg::PROG_CYC
) (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial pins from the host
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic reset_n,
  // Serial output pin
  output logic so,
  output logic so_oe_n,
  // Device state
  output logic busy,
  output logic standby
);
  localparam int BW = $clog2(PROG_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  ////////////////////////////////////////////////////////////////////
  logic [4:0] meta;
  logic [4:0] sync;
  logic sck_d;
  logic cs_d;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_low;
  logic pin_rst;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  // Two flops on every pin, then one delay for edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta <= sfp_pkg::SYNC_RST;
      sync <= sfp_pkg::SYNC_RST;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      meta <= {reset_n, wp_n, si, sck, cs_n};
      sync <= meta;
      sck_d <= sync[1];
      cs_d <= sync[0];
    end
  end

  // SCK edges count only while selected
  assign cs_n_s = sync[0];
  assign sck_s = sync[1];
  assign si_s = sync[2];
  assign wp_low = ~sync[3];
  assign pin_rst = ~sync[4];
  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_d;
  assign cs_rise = cs_n_s & ~cs_d;

  ////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////
  // Next buffer byte, wrapping at the page end
  function automatic logic [9:0] sfp_next_baddr(
    input logic [9:0] a,
    input logic p512
  );
    logic [9:0] last;
    last = p512 ? 10'(sfp_pkg::PAGE_SMALL - 1)
                : 10'(sfp_pkg::PAGE_BIG - 1);
    return (a == last) ? 10'h000 : 10'(a + 10'h001);
  endfunction

  // Sector of a main memory address
  function automatic logic [2:0] sfp_sector(
    input logic [23:0] a,
    input logic p512
  );
    logic [12:0] page;
    page = p512 ? a[21:9] : a[22:10];
    return page[12:10];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Frame state
  ////////////////////////////////////////////////////////////////////
  sfp_pkg::sfp_state_e state;
  sfp_pkg::sfp_state_e next_state;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [9:0] baddr;
  logic [9:0] next_baddr;
  logic [7:0] obyte;
  logic [7:0] next_obyte;
  logic next_so;
  logic next_so_oe_n;
  logic done;
  logic next_done;
  logic buf_we;
  logic byte_in;
  logic [7:0] status_byte;
  logic [7:0] src;

  // Config and timing state
  logic page512;
  logic next_page512;
  logic prot_en;
  logic next_prot_en;
  logic [7:0] sector_prot;
  logic [7:0] next_sector_prot;
  logic [7:0] sector_lock;
  logic [7:0] next_sector_lock;
  logic [BW-1:0] busy_cnt;
  logic [BW-1:0] next_busy_cnt;
  logic next_busy;
  logic next_standby;
  logic [2:0] sec;
  logic blocked;

  sfp_buf_if bus ();

  // Two page buffers
  sfp_page_buf #(
    .BYTES(sfp_pkg::PAGE_BIG)
  ) u_buf (
    .core_clk(core_clk),
    .bus(bus)
  );

  // Buffer access follows the frame
  assign bus.we = buf_we;
  assign bus.sel = addr[sfp_pkg::BUF_SEL_BIT];
  assign bus.addr = baddr;
  assign bus.wdata = next_shreg;

  // Status: ready, wp level, protection on, page size
  assign status_byte = {~busy, ~wp_low, prot_en, page512, 4'h0};
  assign src = (op == sfp_pkg::OP_STATUS) ? status_byte : bus.rdata;

  // Frame sequencer next values
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_shreg = shreg;
    next_addr = addr;
    next_baddr = baddr;
    next_obyte = obyte;
    next_so = so;
    next_so_oe_n = so_oe_n;
    next_done = done;
    buf_we = 1'b0;
    byte_in = 1'b0;
    if (pin_rst) begin
      next_state = sfp_pkg::SFP_IDLE;
      next_so_oe_n = 1'b1;
    end else if (cs_n_s) begin
      next_state = sfp_pkg::SFP_IDLE;
      next_so_oe_n = 1'b1;
    end else if (cs_fall) begin
      next_state = sfp_pkg::SFP_OPC;
      next_cnt = 5'h00;
      next_done = 1'b0;
    end else if (sck_rise) begin
      next_shreg = {shreg[6:0], si_s};
      next_cnt = 5'(cnt + 5'h01);
      unique case (state)
        sfp_pkg::SFP_OPC: begin
          if (cnt == sfp_pkg::OPC_LAST) begin
            next_op = next_shreg;
            next_cnt = 5'h00;
            next_state = sfp_pkg::SFP_SKIP;
            if (busy && next_shreg != sfp_pkg::OP_STATUS) begin
              next_state = sfp_pkg::SFP_SKIP;
            end else begin
              case (next_shreg)
                sfp_pkg::OP_STATUS: begin
                  next_state = sfp_pkg::SFP_RD;
                  next_done = 1'b1;
                end
                sfp_pkg::OP_PROT_WR: next_state = sfp_pkg::SFP_WR;
                sfp_pkg::OP_PROT_EN,
                sfp_pkg::OP_PAGE512: next_done = 1'b1;
                sfp_pkg::OP_BUF_WR,
                sfp_pkg::OP_BUF_RD,
                sfp_pkg::OP_PROG,
                sfp_pkg::OP_ERASE,
                sfp_pkg::OP_LOCK: next_state = sfp_pkg::SFP_ADDR;
                default: next_state = sfp_pkg::SFP_SKIP;
              endcase
            end
          end
        end
        sfp_pkg::SFP_ADDR: begin
          next_addr = {addr[22:0], si_s};
          if (cnt == sfp_pkg::ADDR_LAST) begin
            next_cnt = 5'h00;
            next_done = 1'b1;
            next_baddr = next_addr[9:0];
            if (page512) begin
              next_baddr = {1'b0, next_addr[8:0]};
            end else if (next_addr[9:0] >= 10'(sfp_pkg::PAGE_BIG)) begin
              next_baddr = 10'(next_addr[9:0] - 10'(sfp_pkg::PAGE_BIG));
            end
            if (op == sfp_pkg::OP_BUF_WR) begin
              next_state = sfp_pkg::SFP_WR;
            end else if (op == sfp_pkg::OP_BUF_RD) begin
              next_state = sfp_pkg::SFP_RD;
            end else begin
              next_state = sfp_pkg::SFP_SKIP;
            end
          end
        end
        sfp_pkg::SFP_WR: begin
          if (cnt[2:0] == sfp_pkg::BIT_LAST) begin
            next_cnt = 5'h00;
            byte_in = 1'b1;
            if (op == sfp_pkg::OP_BUF_WR) begin
              buf_we = 1'b1;
              next_baddr = sfp_next_baddr(baddr, page512);
            end else begin
              next_state = sfp_pkg::SFP_SKIP;
            end
          end
        end
        sfp_pkg::SFP_RD,
        sfp_pkg::SFP_SKIP,
        sfp_pkg::SFP_IDLE: next_cnt = cnt;
      endcase
    end else if (sck_fall && state == sfp_pkg::SFP_RD) begin
      // Shift out on the falling edge, first bit of a byte from src
      next_so_oe_n = 1'b0;
      if (cnt[2:0] == 3'h0) begin
        next_so = src[7];
        next_obyte = {src[6:0], 1'b0};
      end else begin
        next_so = obyte[7];
        next_obyte = {obyte[6:0], 1'b0};
      end
      next_cnt = 5'(cnt + 5'h01);
      if (cnt[2:0] == sfp_pkg::BIT_LAST) begin
        next_cnt = 5'h00;
        if (op == sfp_pkg::OP_BUF_RD) begin
          next_baddr = sfp_next_baddr(baddr, page512);
        end
      end
    end
  end

  // Frame sequencer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= sfp_pkg::SFP_IDLE;
      op <= 8'h00;
      cnt <= 5'h00;
      shreg <= 8'h00;
      addr <= 24'h000000;
      baddr <= 10'h000;
      obyte <= 8'h00;
      so <= 1'b0;
      so_oe_n <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      shreg <= next_shreg;
      addr <= next_addr;
      baddr <= next_baddr;
      obyte <= next_obyte;
      so <= next_so;
      so_oe_n <= next_so_oe_n;
      done <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Protection, page size and self-timed operation
  ////////////////////////////////////////////////////////////////////
  assign sec = sfp_sector(addr, page512);
  assign blocked = wp_low | sector_lock[sec]
                 | (prot_en & sector_prot[sec]);

  // Config and busy next values
  always_comb begin
    next_page512 = page512;
    next_prot_en = prot_en;
    next_sector_prot = sector_prot;
    next_sector_lock = sector_lock;
    next_busy = busy;
    next_busy_cnt = busy_cnt;
    if (busy) begin
      // Internal timer, no host timing involved
      next_busy_cnt = BW'(busy_cnt - 1'b1);
      if (busy_cnt == BW'(1)) begin
        next_busy = 1'b0;
      end
    end
    if (pin_rst) begin
      next_busy = 1'b0;
      next_busy_cnt = '0;
    end else if (byte_in && op == sfp_pkg::OP_PROT_WR) begin
      if (!wp_low && !busy) begin
        next_sector_prot = next_shreg;
      end
    end else if (cs_rise && done && !busy) begin
      case (op)
        sfp_pkg::OP_PROG,
        sfp_pkg::OP_ERASE: begin
          if (!blocked) begin
            next_busy = 1'b1;
            next_busy_cnt = BW'(PROG_CYCLES);
          end
        end
        sfp_pkg::OP_PROT_EN: next_prot_en = 1'b1;
        sfp_pkg::OP_LOCK: next_sector_lock[sec] = 1'b1;
        sfp_pkg::OP_PAGE512: next_page512 = 1'b1;
        default: next_busy = busy;
      endcase
    end
    next_standby = cs_n_s & ~next_busy;
  end

  // Config and busy registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page512 <= 1'b0;
      prot_en <= 1'b0;
      sector_prot <= 8'h00;
      sector_lock <= 8'h00;
      busy <= 1'b0;
      busy_cnt <= '0;
      standby <= 1'b1;
    end else begin
      page512 <= next_page512;
      prot_en <= next_prot_en;
      sector_prot <= next_sector_prot;
      sector_lock <= next_sector_lock;
      busy <= next_busy;
      busy_cnt <= next_busy_cnt;
      standby <= next_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////
  frame_start_a:
  assert property (@(posedge core_clk) disable iff (rst)
    cs_fall && !pin_rst |=> state == sfp_pkg::SFP_OPC)
    else $error("select fall did not start a frame");

  so_hiz_a:
  assert property (@(posedge core_clk) disable iff (rst)
    cs_n_s |=> so_oe_n)
    else $error("output driven while deselected");

  standby_wait_a:
  assert property (@(posedge core_clk) disable iff (rst)
    busy |-> !standby)
    else $error("standby during self-timed operation");

  sample_rise_a:
  assert property (@(posedge core_clk) disable iff (rst)
    !sck_rise |=> $stable(shreg))
    else $error("input shifted without a rising edge");

  drive_fall_a:
  assert property (@(posedge core_clk) disable iff (rst)
    !sck_fall |=> $stable(so))
    else $error("output changed without a falling edge");

  ignore_desel_a:
  assert property (@(posedge core_clk) disable iff (rst)
    cs_n_s ##1 cs_n_s |-> state == sfp_pkg::SFP_IDLE
      && $stable(shreg))
    else $error("activity while deselected");

  wp_block_a:
  assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) |-> $past(!wp_low))
    else $error("program started under write protect");

  prot_freeze_a:
  assert property (@(posedge core_clk) disable iff (rst)
    wp_low |=> $stable(sector_prot))
    else $error("protection changed under write protect");

  pin_reset_a:
  assert property (@(posedge core_clk) disable iff (rst)
    pin_rst |=> state == sfp_pkg::SFP_IDLE && !busy)
    else $error("reset pin did not force idle");
endmodule

// File: test/sfp_host_model.sv
// Host serial controller model that drives the flash pins.
module sfp_host_model (
  // Clock
  input wire logic core_clk,
  // Pins to the device
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic reset_n,
  // Pins from the device
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic mode3;
  logic so_line;

  ////////////////////////////////////////////////////////////////////////////
  // Released line shows the inverse of the last driven bit
  assign so_line = so_oe_n ? ~so : so;

  // Idle pin levels, reset pin held high while unused
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    reset_n = 1'b1;
    mode3 = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait a number of core clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One whole frame; bytes seen on the output come back in rx
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n <= 1'b0;
    sck <= mode3;
    tick(6);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sck <= 1'b0;
        si <= tx[i][k];
        tick(6);
        b[k] = so_line;
        sck <= 1'b1;
        tick(6);
      end
      rx.push_back(b);
    end
    sck <= mode3;
    tick(6);
    cs_n <= 1'b1;
    tick(6);
  endtask

  // Pin activity while deselected
  task automatic noise(input logic [15:0] pat);
    for (int k = 0; k < 16; k++) begin
      sck <= pat[k];
      si <= pat[15-k];
      tick(2);
    end
    sck <= mode3;
    tick(2);
  endtask

  // Low pulse on the reset pin
  task automatic pin_reset(input int n);
    reset_n <= 1'b0;
    tick(n);
    reset_n <= 1'b1;
    tick(2);
  endtask
endmodule

// File: test/sfp_flash_pins_tb.sv
// Self-checking bench of the serial flash pin interface.
module sfp_flash_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PC = 400;
  logic core_clk, rst, wp_n, cs_n, sck, si, reset_n, so, so_oe_n;
  logic busy, standby;
  logic [15:0] lfsr = 16'h0009;
  logic [15:0] bcnt = 16'h0000;
  logic [15:0] blen = 16'h0000;
  logic [7:0] got[$], q[$], none[$], d0[$], d1[$];
  logic [7:0] ops[2] = '{sfp_pkg::OP_PROG, sfp_pkg::OP_ERASE};
  logic [23:0] a;
  int err_count = 0;
  int n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Device and host
  sfp_flash_pins #(.PROG_CYCLES(PC)) sfp_flash_pins_inst (.core_clk(core_clk),
    .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .reset_n(reset_n), .so(so), .so_oe_n(so_oe_n), .busy(busy),
    .standby(standby));
  sfp_host_model sfp_host_model_inst (.core_clk(core_clk), .cs_n(cs_n),
    .sck(sck), .si(si), .reset_n(reset_n), .so(so), .so_oe_n(so_oe_n));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Length of each busy period
  always @(posedge core_clk) begin
    if (busy === 1'b1)
      bcnt <= bcnt + 16'h0001;
    else if (bcnt != 16'h0000) begin
      blen <= bcnt;
      bcnt <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Random bytes and expected status
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  function automatic logic [7:0] stat(input logic r, w, p, s);
    return {r, w, p, s, 4'h0};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Opcode, three address bytes, then data
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad,
                     input logic [7:0] d[$]);
    q = {op, ad[23:16], ad[15:8], ad[7:0]};
    q = {q, d};
    sfp_host_model_inst.frame(q, got);
  endtask

  task automatic rd_buf(input logic [23:0] ad, input int n);
    logic [7:0] z[$];
    z = {};
    repeat (n) z.push_back(8'h00);
    cmd(sfp_pkg::OP_BUF_RD, ad, z);
  endtask

  task automatic rd_stat(input logic [7:0] e);
    q = {sfp_pkg::OP_STATUS, 8'h00};
    sfp_host_model_inst.frame(q, got);
    check(got[1], e);
  endtask

  task automatic wait_idle;
    repeat (1000) if (busy !== 1'b0) @(posedge core_clk);
    tick(3);
  endtask

  // Program and erase on one sector, expecting run or refusal
  task automatic prog(input logic [2:0] s, input logic exp);
    foreach (ops[i]) begin
      cmd(ops[i], {1'b0, s, 20'h00000}, none);
      check(busy, exp);
      wait_idle;
      check(standby, 1);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    results;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    none = {};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    tick(3);
    check(so_oe_n, 1);
    check(standby, 1);
    check(busy, 0);
    for (int r = 0; r < 2; r++) begin
      sfp_host_model_inst.mode3 <= r[0];
      d0 = {};
      d1 = {};
      repeat (4) d0.push_back(rnd());
      repeat (4) d1.push_back(rnd());
      a = {15'h0000, rnd(), lfsr[8]};
      cmd(sfp_pkg::OP_BUF_WR, a, d0);
      cmd(sfp_pkg::OP_BUF_WR, a | 24'h800000, d1);
      sfp_host_model_inst.noise(lfsr);
      check(standby, 1);
      rd_buf(a, 4);
      foreach (d0[i]) check(got[i+4], d0[i]);
      check(so_oe_n, 1);
      rd_buf(a | 24'h800000, 4);
      foreach (d1[i]) check(got[i+4], d1[i]);
    end
    // Byte address wraps at the end of a 528-byte page
    q = {8'h5A, 8'hA5};
    cmd(sfp_pkg::OP_BUF_WR, 24'h00020F, q);
    rd_buf(24'h000000, 1);
    check(got[4], 8'hA5);
    rd_stat(stat(1, 1, 0, 0));
    // Self-timed program and erase
    foreach (ops[i]) begin
      cmd(ops[i], 24'h000000, none);
      check(busy, 1);
      check(standby, 0);
      rd_stat(stat(0, 1, 0, 0));
      wait_idle;
      check(blen, PC);
      check(standby, 1);
    end
    // Reset pin aborts a running program
    cmd(sfp_pkg::OP_PROG, 24'h000000, none);
    sfp_host_model_inst.pin_reset(4);
    tick(2);
    check(busy, 0);
    check(standby, 1);
    rd_stat(stat(1, 1, 0, 0));
    // Protection under the write-protect pin
    q = {sfp_pkg::OP_PROT_WR, 8'h01};
    sfp_host_model_inst.frame(q, got);
    wp_n <= 1'b0;
    tick(4);
    q = {sfp_pkg::OP_PROT_WR, 8'hFF};
    sfp_host_model_inst.frame(q, got);
    q = {sfp_pkg::OP_PROT_EN};
    sfp_host_model_inst.frame(q, got);
    cmd(sfp_pkg::OP_LOCK, 24'h300000, none);
    rd_stat(stat(1, 0, 1, 0));
    prog(3'h0, 1'b0);
    prog(3'h1, 1'b0);
    wp_n <= 1'b1;
    tick(4);
    prog(3'h3, 1'b0);
    prog(3'h2, 1'b1);
    // Power-on reset clears protection enable, then select 512-byte pages
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    rd_stat(stat(1, 1, 0, 0));
    q = {sfp_pkg::OP_PAGE512};
    sfp_host_model_inst.frame(q, got);
    rd_stat(stat(1, 1, 0, 1));
    results;
  end
endmodule
